// ### hw/wkt_pkg.sv
// Constants shared by the battery week timer modules
package wkt_pkg;
  localparam int          WKT_AW            = 8;
  localparam logic [7:0]  WKT_OFF_CTRL      = 8'h00;
  localparam logic [7:0]  WKT_OFF_SECS      = 8'h04;
  localparam logic [7:0]  WKT_OFF_CMP       = 8'h08;
  localparam logic [7:0]  WKT_OFF_PRESC     = 8'h0c;
  localparam logic [7:0]  WKT_OFF_RATE      = 8'h10;
  localparam logic [7:0]  WKT_OFF_DCTRL     = 8'h14;
  localparam logic [7:0]  WKT_OFF_DVAL      = 8'h18;
  localparam logic [7:0]  WKT_OFF_BKO       = 8'h1c;
  localparam int          WKT_CTRL_RUN_BIT  = 0;
  localparam int          WKT_CTRL_WAKE_BIT = 6;
  localparam int          WKT_SEC_W         = 28;
  localparam int          WKT_PRE_W         = 15;
  localparam int          WKT_RATE_W        = 4;
  localparam int          WKT_DC_W          = 9;
  localparam int          WKT_TSEL_LSB      = 7;
  localparam int          WKT_TSEL_W        = 3;
  localparam int          WKT_NORELOAD_BIT  = 6;
  localparam int          WKT_PWRGATE_BIT   = 5;
  localparam int          WKT_BKO_W         = 3;
  localparam logic [6:0]  WKT_CTRL_RST      = 7'h01;
  localparam logic [27:0] WKT_SECS_RST      = 28'h0000000;
  localparam logic [27:0] WKT_CMP_RST       = 28'h0ffffff;
  localparam logic [14:0] WKT_PRE_WRAP      = 15'h7fff;
  localparam logic [3:0]  WKT_RATE_RST      = 4'h0;
  localparam logic [9:0]  WKT_DCTRL_RST     = 10'h000;
  localparam logic [8:0]  WKT_DVAL_RST      = 9'h000;
  localparam logic [2:0]  WKT_BKO_RST       = 3'h0;
  typedef enum logic [2:0] {
    WKT_TS_OFF, WKT_TS_SUBSEC, WKT_TS_SEC, WKT_TS_RSVD,
    WKT_TS_W3, WKT_TS_W5, WKT_TS_W7, WKT_TS_W9
  } wkt_tsel_t;
endpackage : wkt_pkg

// ### hw/wkt_link_if.sv
// Signals between the timer core, its prescaler and its write holder
interface wkt_link_if;
  import wkt_pkg::*;
  logic                  tick;
  logic                  run;
  logic [WKT_RATE_W-1:0] rate;
  logic [WKT_PRE_W-1:0]  cnt;
  logic                  wrap;
  logic                  step01;
  logic                  sub_pulse;
  logic                  wr_req;
  logic [WKT_AW-1:0]     wr_addr_in;
  logic [31:0]           wr_data_in;
  logic                  pend;
  logic                  accept;
  logic [WKT_AW-1:0]     pend_addr;
  logic [31:0]           pend_data;
  modport pre  (input tick, run, rate, output cnt, wrap, step01, sub_pulse);
  modport hold (input tick, wr_req, wr_addr_in, wr_data_in,
                output pend, accept, pend_addr, pend_data);
  modport core (output tick, run, rate, wr_req, wr_addr_in, wr_data_in,
                input cnt, wrap, step01, sub_pulse, pend, accept, pend_addr, pend_data);
endinterface : wkt_link_if

// ### hw/wkt_prescaler.sv
// Fifteen bit prescaler with 1 Hz and sub-second events
module wkt_prescaler
  import wkt_pkg::*;
(
  input  wire logic  clk_sys_i,
  input  wire logic  sys_rst_i,
  wkt_link_if.pre    lk
);
  logic [WKT_PRE_W-1:0] cnt_r;
  logic [WKT_PRE_W-1:0] cnt_nxt;
  logic [WKT_PRE_W-1:0] mask;
  logic                 adv;

  assign adv     = lk.tick && lk.run;
  assign cnt_nxt = cnt_r + 15'h0001;
  assign mask    = (lk.rate == WKT_RATE_RST) ? '0 : WKT_PRE_W'((16'h0001 << (5'd15 - {1'b0, lk.rate})) - 16'h0001);
  assign lk.cnt  = cnt_r;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !lk.run) begin
      cnt_r <= '0;
    end else if (adv) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lk.wrap      <= 1'b0;
      lk.step01    <= 1'b0;
      lk.sub_pulse <= 1'b0;
    end else begin
      lk.wrap      <= adv && (cnt_r == WKT_PRE_WRAP);
      lk.step01    <= adv && (cnt_r == '0);
      lk.sub_pulse <= adv && (lk.rate != WKT_RATE_RST) && ((cnt_nxt & mask) == '0);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_wrap_zero;
    lk.wrap |-> (cnt_r == '0);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap without zero count");
  property p_stop_zero;
    !lk.run |=> (cnt_r == '0);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("prescaler not held at zero");
endmodule : wkt_prescaler

// ### hw/wkt_wr_hold.sv
// Holds one register write until the next 32 kHz tick takes it
module wkt_wr_hold
  import wkt_pkg::*;
(
  input  wire logic  clk_sys_i,
  input  wire logic  sys_rst_i,
  wkt_link_if.hold   lk
);
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lk.pend      <= 1'b0;
      lk.pend_addr <= '0;
      lk.pend_data <= '0;
    end else if (lk.pend && lk.tick) begin
      lk.pend <= 1'b0;
    end else if (!lk.pend && lk.wr_req) begin
      lk.pend      <= 1'b1;
      lk.pend_addr <= lk.wr_addr_in;
      lk.pend_data <= lk.wr_data_in;
    end
  end
  assign lk.accept = lk.pend && lk.tick;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_hold_stable;
    lk.pend && !lk.tick |=> lk.pend && $stable(lk.pend_data) && $stable(lk.pend_addr);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("held write changed");
endmodule : wkt_wr_hold

// ### hw/wkt_top.sv
// Battery week timer: registers, seconds counter, down-counter, wake request
// Overview of operation
// - Prescaler is a 15-bit up-counter advancing each 32 kHz tick while running.
// - Prescaler wrap from 7FFF to zero emits the 1 Hz tick.
// - Rate select picks a prescaler bit for down-counter base or sub-second event.
// - A register write completes within one 32 kHz cycle; one made while another is pending is dropped.
// - Each register read returns data in one bus clock cycle.
// - Events of one 32 kHz cycle reach the processor in the same step, except the seconds alarm, one bus clock later.
// - Seconds advance when prescaler steps from zero to one, not at the wrap.
// - Control bit 6 gates the wake output; clearing it resets the output.
// - Control bit 0 runs seconds and prescaler; resets to one.
// - While stopped, seconds hold and later resume from the held value.
// - While stopped, prescaler is forced to zero for lowest power.
// - Seconds occupy bits 27:0, count once per second, reset to zero.
// - Seconds reads are live; reads and writes work whatever the run state.
// - Battery-kept output pins hold firmware-set levels.
// - Wake asserts on seconds at or above compare, or down-counter one to zero.
// - Rate zero disables sub-second events; n gives two to the n Hz.
module wkt_top
  import wkt_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              tick_32k_i,
  input  wire logic [WKT_AW-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic              sys_power_present_i,
  output logic      [31:0]       rdata_o,
  output logic                   wr_pending_o,
  output logic                   wake_o,
  output logic                   one_second_o,
  output logic                   sub_second_o,
  output logic                   seconds_alarm_o,
  output logic                   downcount_alarm_o,
  output logic [WKT_BKO_W-1:0]   battery_kept_output_o
);
  wkt_link_if lk ();

  logic                  run_r;
  logic                  wake_en_r;
  logic [WKT_SEC_W-1:0]  secs_r;
  logic [WKT_SEC_W-1:0]  secs_nxt;
  logic [WKT_SEC_W-1:0]  cmp_r;
  logic [WKT_RATE_W-1:0] rate_r;
  logic [WKT_TSEL_W-1:0] tsel_r;
  logic                  noreload_r;
  logic                  pwrgate_r;
  logic [WKT_DC_W-1:0]   dc_r;
  logic [WKT_DC_W-1:0]   dc_load_r;
  logic [WKT_BKO_W-1:0]  bko_r;
  logic [31:0]           rdata_r;
  logic [31:0]           rd_mux;
  logic                  wake_r;
  logic                  sec_step;
  logic                  dc_tick;
  logic                  dc_expire;
  logic                  sec_match;
  logic                  wr_ctrl;
  logic                  wr_secs;
  logic                  wr_cmp;
  logic                  wr_rate;
  logic                  wr_dctrl;
  logic                  wr_dval;
  logic                  wr_bko;
  logic [31:0]           pd;

  assign lk.tick       = tick_32k_i;
  assign lk.run        = run_r;
  assign lk.rate       = rate_r;
  assign lk.wr_req     = wr_i;
  assign lk.wr_addr_in = addr_i;
  assign lk.wr_data_in = wdata_i;

  wkt_prescaler u_presc (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .lk        (lk.pre)
  );

  wkt_wr_hold u_hold (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .lk        (lk.hold)
  );

  // Writes land on a 32 kHz tick, like the battery-side logic they model
  assign pd       = lk.pend_data;
  assign wr_ctrl  = lk.accept && (lk.pend_addr == WKT_OFF_CTRL);
  assign wr_secs  = lk.accept && (lk.pend_addr == WKT_OFF_SECS);
  assign wr_cmp   = lk.accept && (lk.pend_addr == WKT_OFF_CMP);
  assign wr_rate  = lk.accept && (lk.pend_addr == WKT_OFF_RATE);
  assign wr_dctrl = lk.accept && (lk.pend_addr == WKT_OFF_DCTRL);
  assign wr_dval  = lk.accept && (lk.pend_addr == WKT_OFF_DVAL);
  assign wr_bko   = lk.accept && (lk.pend_addr == WKT_OFF_BKO);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      run_r     <= WKT_CTRL_RST[WKT_CTRL_RUN_BIT];
      wake_en_r <= WKT_CTRL_RST[WKT_CTRL_WAKE_BIT];
    end else if (wr_ctrl) begin
      run_r     <= pd[WKT_CTRL_RUN_BIT];
      wake_en_r <= pd[WKT_CTRL_WAKE_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cmp_r  <= WKT_CMP_RST;
      rate_r <= WKT_RATE_RST;
    end else begin
      if (wr_cmp) begin
        cmp_r <= pd[WKT_SEC_W-1:0];
      end
      if (wr_rate) begin
        rate_r <= pd[WKT_RATE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tsel_r     <= WKT_DCTRL_RST[WKT_TSEL_LSB +: WKT_TSEL_W];
      noreload_r <= WKT_DCTRL_RST[WKT_NORELOAD_BIT];
      pwrgate_r  <= WKT_DCTRL_RST[WKT_PWRGATE_BIT];
      bko_r      <= WKT_BKO_RST;
    end else begin
      if (wr_dctrl) begin
        tsel_r     <= pd[WKT_TSEL_LSB +: WKT_TSEL_W];
        noreload_r <= pd[WKT_NORELOAD_BIT];
        pwrgate_r  <= pd[WKT_PWRGATE_BIT];
      end
      if (wr_bko) begin
        bko_r <= pd[WKT_BKO_W-1:0];
      end
    end
  end

  // Seconds move one tick after the wrap, on the 0 to 1 prescaler step
  assign sec_step = lk.step01 && run_r;
  assign secs_nxt = secs_r + 28'h0000001;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      secs_r <= WKT_SECS_RST;
    end else if (wr_secs) begin
      secs_r <= pd[WKT_SEC_W-1:0];
    end else if (sec_step) begin
      secs_r <= secs_nxt;
    end
  end

  // Down-counter time base; week bits fire when they fall
  always_comb begin
    dc_tick = 1'b0;
    unique case (wkt_tsel_t'(tsel_r))
      WKT_TS_OFF:    dc_tick = 1'b0;
      WKT_TS_SUBSEC: dc_tick = lk.sub_pulse;
      WKT_TS_SEC:    dc_tick = sec_step;
      WKT_TS_RSVD:   dc_tick = 1'b0;
      WKT_TS_W3:     dc_tick = sec_step && (secs_nxt[2:0] == 3'h0);
      WKT_TS_W5:     dc_tick = sec_step && (secs_nxt[4:0] == 5'h00);
      WKT_TS_W7:     dc_tick = sec_step && (secs_nxt[6:0] == 7'h00);
      WKT_TS_W9:     dc_tick = sec_step && (secs_nxt[8:0] == 9'h000);
    endcase
  end

  assign dc_expire = dc_tick && (dc_r == 9'h001);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dc_r      <= WKT_DVAL_RST;
      dc_load_r <= WKT_DVAL_RST;
    end else if (wr_dval) begin
      dc_r      <= pd[WKT_DC_W-1:0];
      dc_load_r <= pd[WKT_DC_W-1:0];
    end else if (dc_expire) begin
      dc_r <= noreload_r ? 9'h000 : dc_load_r;
    end else if (dc_tick && (dc_r != 9'h000)) begin
      dc_r <= dc_r - 9'h001;
    end
  end

  assign sec_match = secs_r >= cmp_r;

  // All events come out of one register stage; a tick's events align except the seconds alarm, one cycle later
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      one_second_o      <= 1'b0;
      sub_second_o      <= 1'b0;
      seconds_alarm_o   <= 1'b0;
      downcount_alarm_o <= 1'b0;
    end else begin
      one_second_o      <= lk.wrap;
      sub_second_o      <= lk.sub_pulse;
      seconds_alarm_o   <= run_r && sec_match;
      downcount_alarm_o <= dc_expire;
    end
  end

  // Enable clear beats any same-cycle event, so the output truly drops
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !wake_en_r) begin
      wake_r <= 1'b0;
    end else if ((sec_match || dc_expire) && (!pwrgate_r || sys_power_present_i)) begin
      wake_r <= 1'b1;
    end
  end
  assign wake_o = wake_r;

  always_comb begin
    rd_mux = '0;
    unique case (addr_i)
      WKT_OFF_CTRL:  rd_mux = {25'h0, wake_en_r, 5'h00, run_r};
      WKT_OFF_SECS:  rd_mux = {4'h0, secs_r};
      WKT_OFF_CMP:   rd_mux = {4'h0, cmp_r};
      WKT_OFF_PRESC: rd_mux = {17'h0, lk.cnt};
      WKT_OFF_RATE:  rd_mux = {28'h0, rate_r};
      WKT_OFF_DCTRL: rd_mux = {22'h0, tsel_r, noreload_r, pwrgate_r, 5'h00};
      WKT_OFF_DVAL:  rd_mux = {7'h0, dc_load_r, 7'h0, dc_r};
      WKT_OFF_BKO:   rd_mux = {29'h0, bko_r};
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !rd_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd_mux;
    end
  end
  assign rdata_o = rdata_r;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_pending_o          <= 1'b0;
      battery_kept_output_o <= WKT_BKO_RST;
    end else begin
      wr_pending_o          <= lk.pend && !lk.tick;
      battery_kept_output_o <= bko_r;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_wrap;
    lk.wrap;
  endsequence
  sequence s_step;
    lk.step01 && run_r && !wr_secs;
  endsequence

  property p_sec_after_step;
    s_step |=> secs_r == $past(secs_nxt);
  endproperty
  a_sec_after_step: assert property (p_sec_after_step) else $error("seconds missed step");

  property p_no_sec_at_wrap;
    s_wrap |-> !lk.step01;
  endproperty
  a_no_sec_at_wrap: assert property (p_no_sec_at_wrap) else $error("wrap and step together");

  property p_sec_hold;
    !run_r && !wr_secs |=> $stable(secs_r);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("seconds moved while stopped");

  property p_wake_off;
    !wake_en_r |=> !wake_o;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake high while disabled");

  property p_wake_set;
    wake_en_r && sec_match && !pwrgate_r && !wr_ctrl |=> wake_o;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake missed match");

  property p_read_one;
    rd_i |=> rdata_o == $past(rd_mux);
  endproperty
  a_read_one: assert property (p_read_one) else $error("read data wrong");

  property p_read_only_once;
    !rd_i |=> rdata_o == '0;
  endproperty
  a_read_only_once: assert property (p_read_only_once) else $error("read data lingers");

  property p_events_aligned;
    lk.wrap && lk.sub_pulse |=> one_second_o && sub_second_o;
  endproperty
  a_events_aligned: assert property (p_events_aligned) else $error("events split");

  property p_wr_lands;
    lk.accept && lk.pend_addr == WKT_OFF_CTRL |=> run_r == $past(pd[WKT_CTRL_RUN_BIT]);
  endproperty
  a_wr_lands: assert property (p_wr_lands) else $error("control write lost");

  sequence s_expire;
    dc_expire && !wr_dval;
  endsequence

  property p_one_sec_out;
    s_wrap |=> one_second_o;
  endproperty
  a_one_sec_out: assert property (p_one_sec_out) else $error("one second pulse missing");

  property p_expire_out;
    dc_expire |=> downcount_alarm_o;
  endproperty
  a_expire_out: assert property (p_expire_out) else $error("expiry pulse missing");

  // One-shot mode must park at zero, or it would reload and fire again dc_load_r ticks later
  property p_no_reload;
    s_expire && noreload_r |=> dc_r == '0;
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("one-shot counter reloaded");

  property p_secs_write;
    wr_secs |=> secs_r == $past(pd[WKT_SEC_W-1:0]);
  endproperty
  a_secs_write: assert property (p_secs_write) else $error("seconds write lost");

  property p_alarm_level;
    run_r && sec_match |=> seconds_alarm_o;
  endproperty
  a_alarm_level: assert property (p_alarm_level) else $error("seconds alarm missing");

  property p_wake_gated;
    pwrgate_r && !sys_power_present_i && !wake_o |=> !wake_o;
  endproperty
  a_wake_gated: assert property (p_wake_gated) else $error("wake without power");

  property p_rate_reserved;
    rd_i && addr_i == WKT_OFF_RATE |=> rdata_o[31:WKT_RATE_W] == '0;
  endproperty
  a_rate_reserved: assert property (p_rate_reserved) else $error("reserved bits set");

  property p_kept_out;
    wr_bko |-> ##2 battery_kept_output_o == $past(pd[WKT_BKO_W-1:0], 2);
  endproperty
  a_kept_out: assert property (p_kept_out) else $error("kept output not updated");
endmodule : wkt_top

// ### tb/tb_wkt_top.sv
// Self-checking bench for the battery week timer top level
module tb_wkt_top
  import wkt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk_sys_i;
  logic                 sys_rst_i;
  logic                 tick_32k_i;
  logic [WKT_AW-1:0]    addr_i;
  logic [31:0]          wdata_i;
  logic                 wr_i;
  logic                 rd_i;
  logic                 sys_power_present_i;
  logic [31:0]          rdata_o;
  logic                 wr_pending_o;
  logic                 wake_o;
  logic                 one_second_o;
  logic                 sub_second_o;
  logic                 seconds_alarm_o;
  logic                 downcount_alarm_o;
  logic [WKT_BKO_W-1:0] battery_kept_output_o;
  int                   miscompares;
  int                   num_checks;
  logic [31:0]          n_sec;
  logic [31:0]          n_sub;
  logic [31:0]          n_dc;
  logic [31:0]          v0;
  logic [31:0]          v1;
  logic [31:0]          c;
  logic [7:0]           ra [9];
  logic [31:0]          rv [9];
  int                   rates [7];

  wkt_top i_dut (
    .clk_sys_i             (clk_sys_i),
    .sys_rst_i             (sys_rst_i),
    .tick_32k_i            (tick_32k_i),
    .addr_i                (addr_i),
    .wdata_i               (wdata_i),
    .wr_i                  (wr_i),
    .rd_i                  (rd_i),
    .sys_power_present_i   (sys_power_present_i),
    .rdata_o               (rdata_o),
    .wr_pending_o          (wr_pending_o),
    .wake_o                (wake_o),
    .one_second_o          (one_second_o),
    .sub_second_o          (sub_second_o),
    .seconds_alarm_o       (seconds_alarm_o),
    .downcount_alarm_o     (downcount_alarm_o),
    .battery_kept_output_o (battery_kept_output_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Pulse counters, so single-cycle events are never missed by a poll
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      n_sec <= 32'h0;
      n_sub <= 32'h0;
      n_dc  <= 32'h0;
    end else begin
      if (one_second_o === 1'b1) n_sec <= n_sec + 32'h1;
      if (sub_second_o === 1'b1) n_sub <= n_sub + 32'h1;
      if (downcount_alarm_o === 1'b1) n_dc <= n_dc + 32'h1;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : idle

  // Ticks are spaced two system cycles apart, one cycle high and one cycle low
  task automatic tick_n(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      tick_32k_i <= 1'b1;
      @(posedge clk_sys_i);
      tick_32k_i <= 1'b0;
    end
  endtask : tick_n

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clk_sys_i);
    #1 chk("rdata after slot", 32'h0, rdata_o);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), exp, v);
  endtask : rdc

  task automatic wr_raw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr_raw

  // A write only lands on the next 32 kHz tick, so one tick is spent here
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_raw(a, d);
    tick_n(1);
    idle(1);
    chk("pending cleared", 32'h0, 32'(wr_pending_o));
  endtask : wr

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    sys_rst_i           = 1'b1;
    tick_32k_i          = 1'b0;
    addr_i              = '0;
    wdata_i             = 32'h0;
    wr_i                = 1'b0;
    rd_i                = 1'b0;
    sys_power_present_i = 1'b1;
    miscompares         = 0;
    num_checks          = 0;
    ra = '{WKT_OFF_CTRL, WKT_OFF_SECS, WKT_OFF_CMP, WKT_OFF_PRESC, WKT_OFF_RATE,
           WKT_OFF_DCTRL, WKT_OFF_DVAL, WKT_OFF_BKO, 8'h20};
    rv = '{32'h1, 32'h0, 32'h0ffffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    rates = '{0, 10, 11, 12, 13, 14, 15};
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    idle(1);
    chk("wake after reset", 32'h0, 32'(wake_o));
    foreach (ra[i]) rdc(ra[i], rv[i]);
    $display("test reset values done");

    wr_raw(WKT_OFF_CTRL, 32'hffffffff);
    idle(3);
    chk("pending held", 32'h1, 32'(wr_pending_o));
    wr_raw(WKT_OFF_SECS, 32'h55);
    rdc(WKT_OFF_CTRL, 32'h1);
    tick_n(1);
    idle(1);
    chk("pending after tick", 32'h0, 32'(wr_pending_o));
    rdc(WKT_OFF_CTRL, 32'h41);
    // First tick after reset steps the prescaler 0 to 1 and so moves seconds
    rdc(WKT_OFF_SECS, 32'h1);
    $display("test write hand-over done");

    wr(WKT_OFF_CTRL, 32'h0);
    rdc(WKT_OFF_PRESC, 32'h0);
    wr(WKT_OFF_PRESC, 32'h1234);
    rdc(WKT_OFF_PRESC, 32'h0);
    wr(WKT_OFF_SECS, 32'hf1234567);
    rdc(WKT_OFF_SECS, 32'h1234567);
    tick_n(3);
    rdc(WKT_OFF_SECS, 32'h1234567);
    wr(WKT_OFF_CMP, 32'h1234560);
    chk("wake inhibited", 32'h0, 32'(wake_o));
    wr(WKT_OFF_CTRL, 32'h40);
    idle(2);
    chk("wake on compare", 32'h1, 32'(wake_o));
    wr(WKT_OFF_CTRL, 32'h41);
    idle(2);
    chk("seconds alarm", 32'h1, 32'(seconds_alarm_o));
    wr(WKT_OFF_CTRL, 32'h01);
    idle(2);
    chk("wake cleared", 32'h0, 32'(wake_o));
    wr(WKT_OFF_DCTRL, 32'h20);
    @(posedge clk_sys_i);
    sys_power_present_i <= 1'b0;
    wr(WKT_OFF_CTRL, 32'h41);
    idle(2);
    chk("wake gated by power", 32'h0, 32'(wake_o));
    @(posedge clk_sys_i);
    sys_power_present_i <= 1'b1;
    idle(3);
    chk("wake with power", 32'h1, 32'(wake_o));
    wr(WKT_OFF_CTRL, 32'h01);
    wr(WKT_OFF_DCTRL, 32'h0);
    $display("test hold and wake done");

    // Fastest rate, so a sub-second event lands on the wrap tick too
    wr(WKT_OFF_RATE, 32'hf);
    rd(WKT_OFF_PRESC, v0);
    tick_n(5);
    rd(WKT_OFF_PRESC, v1);
    chk("prescaler step", v0 + 32'h5, v1);
    tick_n(32767 - int'(v1));
    rdc(WKT_OFF_PRESC, 32'h7fff);
    rd(WKT_OFF_SECS, v0);
    c = n_sec;
    tick_n(1);
    idle(2);
    chk("one second pulse", c + 32'h1, n_sec);
    rdc(WKT_OFF_PRESC, 32'h0);
    rdc(WKT_OFF_SECS, v0);
    tick_n(1);
    idle(2);
    rdc(WKT_OFF_SECS, v0 + 32'h1);
    $display("test one second done");

    foreach (rates[i]) begin
      wr(WKT_OFF_RATE, 32'(rates[i]));
      idle(2);
      c = n_sub;
      tick_n(rates[i] == 0 ? 64 : 4 << (15 - rates[i]));
      idle(3);
      chk("sub-second count", rates[i] == 0 ? 32'h0 : 32'h4, n_sub - c);
    end
    $display("test sub-second rates done");

    wr(WKT_OFF_RATE, 32'hf);
    wr(WKT_OFF_DCTRL, 32'h0c0);
    wr(WKT_OFF_CMP, 32'hffffffff);
    rdc(WKT_OFF_CMP, 32'h0fffffff);
    wr(WKT_OFF_CTRL, 32'h41);
    idle(2);
    chk("no wake before expiry", 32'h0, 32'(wake_o));
    c = n_dc;
    wr(WKT_OFF_DVAL, 32'h3);
    tick_n(6);
    idle(2);
    chk("one expiry", c + 32'h1, n_dc);
    chk("wake on expiry", 32'h1, 32'(wake_o));
    rdc(WKT_OFF_DVAL, 32'h00030000);
    wr(WKT_OFF_CTRL, 32'h01);
    idle(2);
    chk("wake dropped", 32'h0, 32'(wake_o));
    $display("test down-counter done");

    wr(WKT_OFF_DCTRL, 32'h200);
    wr(WKT_OFF_DVAL, 32'h0);
    wr(WKT_OFF_SECS, 32'h7);
    wr(WKT_OFF_DVAL, 32'h1);
    rdc(WKT_OFF_DVAL, 32'h00010001);
    $display("test seconds rewrite done");

    wr(WKT_OFF_BKO, 32'h5);
    chk("kept outputs", 32'h5, 32'(battery_kept_output_o));
    wr(WKT_OFF_BKO, 32'hfffffffa);
    chk("kept outputs", 32'h2, 32'(battery_kept_output_o));
    rdc(WKT_OFF_BKO, 32'h2);
    $display("test kept outputs done");

    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    idle(1);
    rdc(WKT_OFF_BKO, 32'h0);
    rdc(WKT_OFF_CTRL, 32'h1);
    wr(WKT_OFF_BKO, 32'h3);
    chk("kept outputs", 32'h3, 32'(battery_kept_output_o));
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : tb_wkt_top
